// ==== core/sercmd_cfg.svh ====
`ifndef SERCMD_CFG_SVH
`define SERCMD_CFG_SVH
// Clock rate and serial framing.
`define CLK_HZ        20000000
`define BAUD_DIV(b)   ((`CLK_HZ + (b) / 2) / (b))
`define FRAME_BITS    4'h9
// Command and answer bytes.
`define OP_WRITE      8'h57
`define OP_READ       8'h52
`define RSP_ACK       8'h06
`define RSP_NAK       8'h15
// Error codes.
`define ERR_NONE      8'h00
`define ERR_OPCODE    8'h01
`define ERR_TIMEOUT   8'h02
`define ERR_MAX       8'h05
`define ERR_SUPER     8'h07
`define ERR_MODE      8'h08
// Command lengths in bytes, opcode included.
`define LEN_WRITE     3'h7
`define LEN_READ      3'h3
// Address map.
`define ADDR_BOOT     16'h5000
`define ADDR_SEL      16'h6060
`define ADDR_LOAD     16'h6064
`define ADDR_SAVE     16'h6068
`define MFG_TOP       4'h7
`define WS_TOP        12'h0040
// Configuration sets.
`define SET_FACTORY   3'h0
`define SET_LAST      3'h4
`define FACT_WORD     32'h0000_0000
// Inter-byte limit and reply buffer.
`define TIMEOUT_MS    100
`define FIFO_DEPTH    16
`endif

// ==== core/sercmd_engine.sv ====
// How it works
// - Characters are one start, eight data, one stop bit, no parity, no flow control.
// - Bit rate selects 9600 to 115200 baud; 115200 is the default code.
// - Each transaction carries a 16-bit address and a 32-bit data word.
// - Narrow registers sit right-aligned; unused upper bits read as zero.
// - A good write answers with one byte 0x06.
// - A failed write answers 0x15 then the error code.
// - A read answers 0x06 then four data bytes MSB first.
// - Reads never answer not-acknowledge except for a bad opcode.
// - Reads of unmapped addresses answer 0x06 and four zero bytes.
// - Codes: 0 none, 1 bad opcode, 2 timeout, 3 checksum, 4 min, 5 max.
// - Codes: 6 gain control fault, 7 supervisory violation, 8 unsupported mode.
// - Live settings sit in a volatile workspace reached by all commands.
// - The factory set is read-only and is never overwritten by a save.
// - Four non-volatile user sets can save and restore the workspace.
// - After reset the workspace loads from the set named by boot control.
// - Load command fills the workspace; save command stores it to a user set.
// - Set selector is 3 bits: 0 factory, 1 to 4 user, 5 to 7 reserved.
// - Manufacturing writes and factory saves need supervisory mode, else code 7.
`timescale 1ns/1ps
`include "sercmd_cfg.svh"

// Byte FIFO between the engine and the transmitter.
module reply_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              push = in_valid_in && in_ready_out;
   wire              pop  = out_valid_out && out_ready_in;

   // Full when the pointers differ only in the wrap bit.
   assign in_ready_out  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid_out = (wr_ptr != rd_ptr);
   assign out_data_out  = mem[rd_ptr[AW-1:0]];

   // Storage is written only on an accepted push.
   always_ff @(posedge clk_in) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data_in;
   end

   // Pointer update.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : reply_fifo

module sercmd_engine
   import sercmd_pkg::*;
#(
   parameter int TIMEOUT_CYC = `TIMEOUT_MS * (`CLK_HZ / 1000)
) (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_b_in,
   input  wire logic       rxd_in,
   input  wire logic [2:0] baud_sel_in,
   input  wire logic       super_en_in,
   output logic            txd_out,
   output logic            busy_out
);
   logic        rst_q1, rst_n;
   logic        rx_m, rx_s, rx_busy, rx_vld;
   logic [3:0]  rx_bit;
   logic [15:0] rx_tmr;
   logic [7:0]  rx_sh, rx_byte;
   logic        tx_busy;
   logic [3:0]  tx_bit;
   logic [15:0] tx_tmr;
   logic [8:0]  tx_sh;
   eng_state_t  state;
   logic [7:0]  op;
   logic [2:0]  cnt, rep_len, sel, copy_set, nv_boot;
   logic [47:0] cmd_sh;
   logic [39:0] rep_sh;
   logic [3:0]  copy_idx;
   logic        copy_save;
   logic [31:0] to_cnt;
   logic [31:0] ws [0:15];
   logic [31:0] um [0:63];
   logic        f_ready, f_valid;
   logic [7:0]  f_data;

   // Reset release through two flip-flops.
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   // Bit period from the rate code; unknown codes use the default rate.
   wire [15:0] bit_div = (baud_sel_in == 3'h1) ? 16'(`BAUD_DIV(9600)) :
                         (baud_sel_in == 3'h2) ? 16'(`BAUD_DIV(19200)) :
                         (baud_sel_in == 3'h3) ? 16'(`BAUD_DIV(38400)) :
                         (baud_sel_in == 3'h4) ? 16'(`BAUD_DIV(57600)) :
                         16'(`BAUD_DIV(115200));

   // Receiver: samples mid-bit, checks the stop bit, no parity.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         rx_m <= 1'b1; rx_s <= 1'b1; rx_busy <= 1'b0; rx_vld <= 1'b0;
         rx_bit <= 4'h0; rx_tmr <= 16'h0000; rx_sh <= 8'h00; rx_byte <= 8'h00;
      end else begin
         rx_m   <= rxd_in;
         rx_s   <= rx_m;
         rx_vld <= 1'b0;
         if (!rx_busy) begin
            if (!rx_s) begin
               rx_busy <= 1'b1;
               rx_bit  <= 4'h0;
               rx_tmr  <= bit_div >> 1;
            end
         end else if (rx_tmr != 16'h0000) begin
            rx_tmr <= rx_tmr - 16'h0001;
         end else begin
            rx_tmr <= bit_div - 16'h0001;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_s) rx_busy <= 1'b0;
            else if (rx_bit != 4'h0 && rx_bit < `FRAME_BITS) rx_sh <= {rx_s, rx_sh[7:1]};
            else if (rx_bit == `FRAME_BITS) begin
               rx_busy <= 1'b0;
               rx_vld  <= rx_s;
               rx_byte <= rx_sh;
            end
         end
      end
   end

   // Transmitter: start bit, eight data bits LSB first, stop bit.
   wire tx_load = !tx_busy && f_valid;
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         txd_out <= 1'b1; tx_busy <= 1'b0; tx_bit <= 4'h0;
         tx_tmr <= 16'h0000; tx_sh <= 9'h1ff;
      end else if (tx_load) begin
         txd_out <= 1'b0;
         tx_sh   <= {1'b1, f_data};
         tx_bit  <= `FRAME_BITS;
         tx_tmr  <= bit_div - 16'h0001;
         tx_busy <= 1'b1;
      end else if (tx_busy) begin
         if (tx_tmr != 16'h0000) tx_tmr <= tx_tmr - 16'h0001;
         else if (tx_bit == 4'h0) tx_busy <= 1'b0;
         else begin
            txd_out <= tx_sh[0];
            tx_sh   <= {1'b1, tx_sh[8:1]};
            tx_bit  <= tx_bit - 4'h1;
            tx_tmr  <= bit_div - 16'h0001;
         end
      end
   end

   reply_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk_in        (clk_sys_in),
      .rst_n_in      (rst_n),
      .in_valid_in   (state == ST_REPLY && rep_len != 3'h0),
      .in_ready_out  (f_ready),
      .in_data_in    (rep_sh[39:32]),
      .out_valid_out (f_valid),
      .out_ready_in  (!tx_busy),
      .out_data_out  (f_data)
   );

   // Command fields; the read address is taken high byte first.
   wire [15:0] w_addr = cmd_sh[47:32];
   wire [31:0] w_data = cmd_sh[31:0];
   wire [15:0] r_addr = cmd_sh[15:0];
   wire        w_ws   = (w_addr[15:4] == `WS_TOP);
   wire        r_ws   = (r_addr[15:4] == `WS_TOP);
   wire        w_mfg  = (w_addr[15:12] == `MFG_TOP);
   wire        sel_rs = (sel > `SET_LAST);
   wire        first_ok = (rx_byte == `OP_WRITE) || (rx_byte == `OP_READ);
   wire        cmd_end = (op == `OP_WRITE) ? (cnt == `LEN_WRITE - 3'h1) :
                                             (cnt == `LEN_READ - 3'h1);
   wire        to_hit = (to_cnt == 32'(TIMEOUT_CYC - 1));

   // Write checks in priority order.
   wire [7:0] w_err =
      (w_mfg && !super_en_in) ? `ERR_SUPER :
      ((w_addr == `ADDR_SEL || w_addr == `ADDR_BOOT) && w_data > 32'(`SET_LAST)) ? `ERR_MAX :
      ((w_addr == `ADDR_LOAD || w_addr == `ADDR_SAVE) && sel_rs) ? `ERR_MODE :
      (w_addr == `ADDR_SAVE && sel == `SET_FACTORY && !super_en_in) ? `ERR_SUPER :
      `ERR_NONE;

   // Read data, right-aligned, zero for unmapped addresses.
   wire        r_hit  = r_ws || r_addr == `ADDR_SEL || r_addr == `ADDR_BOOT;
   wire [31:0] r_data = r_ws ? ws[r_addr[3:0]] :
                        (r_addr == `ADDR_SEL) ? {29'h0000_0000, sel} :
                        (r_addr == `ADDR_BOOT) ? {29'h0000_0000, nv_boot} :
                        32'h0000_0000;

   // Copy path; a save to the factory set never starts a copy.
   wire        wr_ok   = state == ST_EXEC && op == `OP_WRITE && w_err == `ERR_NONE;
   wire        go_copy = w_addr == `ADDR_LOAD ||
                         (w_addr == `ADDR_SAVE && sel != `SET_FACTORY);
   wire [2:0]  set_m1  = copy_set - 3'h1;
   wire [5:0]  um_idx  = {set_m1[1:0], copy_idx};
   wire        ws_we   = (wr_ok && w_ws) || (state == ST_COPY && !copy_save);
   wire [3:0]  ws_wa   = (state == ST_COPY) ? copy_idx : w_addr[3:0];
   wire [31:0] ws_wd   = (state != ST_COPY) ? w_data :
                         (copy_set == `SET_FACTORY) ? `FACT_WORD : um[um_idx];
   wire        um_we   = state == ST_COPY && copy_save;
   wire [2:0]  boot_pick = (nv_boot == 3'h1 || nv_boot == 3'h2 || nv_boot == 3'h3 ||
                            nv_boot == 3'h4) ? nv_boot : `SET_FACTORY;

   // Workspace, user sets and boot control are memories without reset.
   always_ff @(posedge clk_sys_in) begin
      if (ws_we) ws[ws_wa] <= ws_wd;
      if (um_we) um[um_idx] <= ws[copy_idx];
      if (wr_ok && w_addr == `ADDR_BOOT) nv_boot <= w_data[2:0];
   end

   // Inter-byte timer runs only inside a partly received command.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) to_cnt <= 32'h0000_0000;
      else if (state != ST_IDLE || rx_vld || cnt == 3'h0) to_cnt <= 32'h0000_0000;
      else to_cnt <= to_cnt + 32'h0000_0001;
   end

   // Command engine.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_BOOT; op <= 8'h00; cnt <= 3'h0; cmd_sh <= 48'h0000_0000_0000;
         rep_sh <= 40'h00_0000_0000; rep_len <= 3'h0; sel <= `SET_FACTORY;
         copy_set <= `SET_FACTORY; copy_idx <= 4'h0; copy_save <= 1'b0;
      end else begin
         case (state)
            ST_BOOT: begin
               copy_set  <= boot_pick;
               copy_save <= 1'b0;
               copy_idx  <= 4'h0;
               rep_len   <= 3'h0;
               state     <= ST_COPY;
            end
            ST_IDLE: begin
               if (rx_vld && cnt == 3'h0) begin
                  op <= rx_byte;
                  if (first_ok) cnt <= 3'h1;
                  else begin
                     rep_sh  <= {`RSP_NAK, `ERR_OPCODE, 24'h00_0000};
                     rep_len <= 3'h2;
                     state   <= ST_REPLY;
                  end
               end else if (rx_vld) begin
                  cmd_sh <= {cmd_sh[39:0], rx_byte};
                  cnt    <= cnt + 3'h1;
                  if (cmd_end) state <= ST_EXEC;
               end else if (to_hit) begin
                  cnt <= 3'h0;
                  if (op == `OP_WRITE) begin
                     rep_sh  <= {`RSP_NAK, `ERR_TIMEOUT, 24'h00_0000};
                     rep_len <= 3'h2;
                     state   <= ST_REPLY;
                  end
               end
            end
            ST_EXEC: begin
               copy_idx  <= 4'h0;
               copy_set  <= sel;
               copy_save <= (w_addr == `ADDR_SAVE);
               if (op == `OP_READ) begin
                  rep_sh  <= {`RSP_ACK, r_data};
                  rep_len <= 3'h5;
                  state   <= ST_REPLY;
               end else if (w_err != `ERR_NONE) begin
                  rep_sh  <= {`RSP_NAK, w_err, 24'h00_0000};
                  rep_len <= 3'h2;
                  state   <= ST_REPLY;
               end else begin
                  rep_sh  <= {`RSP_ACK, 32'h0000_0000};
                  rep_len <= 3'h1;
                  if (w_addr == `ADDR_SEL) sel <= w_data[2:0];
                  state   <= go_copy ? ST_COPY : ST_REPLY;
               end
            end
            ST_COPY: begin
               copy_idx <= copy_idx + 4'h1;
               if (copy_idx == 4'hf) state <= ST_REPLY;
            end
            ST_REPLY: begin
               if (rep_len == 3'h0) state <= ST_DRAIN;
               else if (f_ready) begin
                  rep_sh  <= {rep_sh[31:0], 8'h00};
                  rep_len <= rep_len - 3'h1;
               end
            end
            ST_DRAIN: begin
               cnt <= 3'h0;
               if (!f_valid && !tx_busy) state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign busy_out = (state != ST_IDLE);

   // Checks on the answers, the save target and the boot load.
   AST_ACK_ONE: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      wr_ok |=> rep_len == 3'h1 && rep_sh[39:32] == `RSP_ACK)
      else $error("write ack not a single 0x06");
   AST_NAK_TWO: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_EXEC && op == `OP_WRITE && w_err != `ERR_NONE) |=>
      state == ST_REPLY && rep_len == 3'h2 && rep_sh[39:32] == `RSP_NAK &&
      rep_sh[31:24] == $past(w_err))
      else $error("write error reply malformed");
   AST_READ_FIVE: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_EXEC && op == `OP_READ) |=>
      rep_len == 3'h5 && rep_sh[39:32] == `RSP_ACK && rep_sh[31:0] == $past(r_data))
      else $error("read reply malformed");
   AST_UNMAPPED: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_EXEC && op == `OP_READ && !r_hit) |=> rep_sh[31:0] == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_BAD_OP: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_IDLE && rx_vld && cnt == 3'h0 && !first_ok) |=>
      rep_sh[31:24] == `ERR_OPCODE && rep_len == 3'h2)
      else $error("bad opcode not refused");
   AST_SUPER: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_EXEC && op == `OP_WRITE && w_mfg && !super_en_in) |=>
      rep_sh[31:24] == `ERR_SUPER)
      else $error("manufacturing write not refused");
   AST_FACT_RO: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      um_we |-> copy_set != `SET_FACTORY && copy_set <= `SET_LAST)
      else $error("save aimed at a read-only set");
   AST_BOOT_LOAD: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      state == ST_BOOT |=> state == ST_COPY && !copy_save ##16 state == ST_REPLY)
      else $error("boot load sequence wrong");
   AST_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_DRAIN && (f_valid || tx_busy)) |=> state == ST_DRAIN)
      else $error("new command accepted before reply sent");
   AST_START: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      tx_load |=> !txd_out [*2])
      else $error("start bit missing");

   COV_WRITE: cover property (@(posedge clk_sys_in) disable iff (!rst_n) wr_ok);
   COV_READ: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
      state == ST_EXEC && op == `OP_READ);
   COV_TIMEOUT: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
      state == ST_IDLE && to_hit);
   COV_SAVE: cover property (@(posedge clk_sys_in) disable iff (!rst_n) um_we);
endmodule : sercmd_engine

// ==== core/sercmd_pkg.sv ====
package sercmd_pkg;
   // Engine states, one-hot.
   typedef enum logic [5:0] {
      ST_BOOT  = 6'b000001,
      ST_IDLE  = 6'b000010,
      ST_EXEC  = 6'b000100,
      ST_COPY  = 6'b001000,
      ST_REPLY = 6'b010000,
      ST_DRAIN = 6'b100000
   } eng_state_t;
endpackage : sercmd_pkg

// ==== test/host_uart.sv ====
`timescale 1ns/1ps

// Host end of the serial link: frames command bytes and collects reply bytes.
module host_uart #(
   parameter int BIT_CYC = 174
) (
   input  wire logic clk_in,
   input  wire logic line_in,
   output logic      line_out
);
   logic [7:0] rx_q[$];
   int         frame_errs;

   // The line idles high until the first command.
   initial begin
      line_out = 1'b1;
      frame_errs = 0;
   end

   // Sends one character LSB first; each bit changes on a falling edge.
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out = frame[i];
         repeat (BIT_CYC) @(negedge clk_in);
      end
   endtask : send_byte

   // Samples each reply bit in its middle and counts characters with a low stop bit.
   initial begin : rx_proc
      logic [7:0] b;
      forever begin
         @(negedge line_in);
         repeat (BIT_CYC / 2) @(posedge clk_in);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_in);
            b[i] = line_in;
         end
         repeat (BIT_CYC) @(posedge clk_in);
         if (line_in !== 1'b1) frame_errs++;
         rx_q.push_back(b);
      end
   end
endmodule : host_uart

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`include "sercmd_cfg.svh"

module testbench;
   localparam int BIT_CYC = `BAUD_DIV(115200);
   localparam int TMO_CYC = 3000;
   localparam int LIMIT   = 100000;
   logic       clk = 1'b0;
   logic       rst_b, rxd, txd, busy, super_en;
   logic [2:0] baud_sel;
   logic [15:0] addr;
   logic [31:0] data;
   int         fails = 0;
   int         compares = 0;
   int         cycles = 0;

   sercmd_engine #(.TIMEOUT_CYC(TMO_CYC)) i_sercmd_engine (
      .clk_sys_in(clk), .rst_b_in(rst_b), .rxd_in(rxd), .baud_sel_in(baud_sel),
      .super_en_in(super_en), .txd_out(txd), .busy_out(busy));
   host_uart #(.BIT_CYC(BIT_CYC)) i_host_uart (.clk_in(clk), .line_in(txd), .line_out(rxd));

   // Free-running 20 MHz clock.
   always #25 clk = ~clk;

   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Waits, bounded, until n reply bytes have arrived.
   task automatic wait_rx(input int n);
      int c;
      c = 0;
      while (i_host_uart.rx_q.size() < n && c < TMO_CYC + 12 * BIT_CYC * 6) begin
         @(negedge clk);
         c++;
      end
   endtask : wait_rx

   // Sends a command, checks the engine is busy when the first reply byte arrives, then checks the reply.
   task automatic command(input logic [7:0] cmd[$], input logic [7:0] exp[$]);
      int c;
      i_host_uart.rx_q.delete();
      foreach (cmd[i]) i_host_uart.send_byte(cmd[i]);
      wait_rx(1);
      check(busy, 1);
      wait_rx(exp.size());
      c = 0;
      while (busy !== 1'b0 && c < 4 * BIT_CYC) begin
         @(negedge clk);
         c++;
      end
      check(i_host_uart.rx_q.size(), exp.size());
      foreach (exp[i]) check(i_host_uart.rx_q[i], exp[i]);
   endtask : command

   // Follows the engine's reply buffer during one reply: order, count, never full, empty after.
   task automatic fifo_watch(input logic [7:0] exp[$]);
      int   n;
      int   pushes;
      int   c;
      logic full_seen;
      n = 0;
      pushes = 0;
      c = 0;
      full_seen = 1'b0;
      while (n < exp.size() && c < 20 * 10 * BIT_CYC) begin
         @(negedge clk);
         c++;
         if (i_sercmd_engine.u_fifo.in_ready_out !== 1'b1) full_seen = 1'b1;
         if (i_sercmd_engine.u_fifo.in_valid_in === 1'b1) pushes++;
         if (i_sercmd_engine.u_fifo.out_valid_out === 1'b1 &&
             i_sercmd_engine.u_fifo.out_ready_in === 1'b1) begin
            check(i_sercmd_engine.u_fifo.out_data_out, exp[n]);
            n++;
         end
      end
      @(negedge clk);
      check(n, exp.size());
      check(pushes, exp.size());
      check(full_seen, 0);
      check(i_sercmd_engine.u_fifo.out_valid_out, 0);
   endtask : fifo_watch

   task automatic stop_test();
      if (fails == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   // Main sequence: reset, a workspace write, a read with the buffer test, then one command each for unmapped read, bad opcode, supervisory, max and timeout.
   initial begin
      rst_b = 1'b0;
      baud_sel = 3'h0;
      super_en = 1'b0;
      void'($urandom(25));
      baud_sel = ($urandom % 2) ? 3'h5 : 3'h0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (40) @(negedge clk);
      check(busy, 0);
      addr = {12'h040, 4'($urandom)};
      data = $urandom;
      command('{`OP_WRITE, addr[15:8], addr[7:0], data[31:24], data[23:16], data[15:8],
                data[7:0]}, '{`RSP_ACK});
      fork
         command('{`OP_READ, addr[15:8], addr[7:0]}, '{`RSP_ACK, data[31:24], data[23:16],
                   data[15:8], data[7:0]});
         fifo_watch('{`RSP_ACK, data[31:24], data[23:16], data[15:8], data[7:0]});
      join
      command('{`OP_READ, 8'h21, 8'($urandom)}, '{`RSP_ACK, 8'h00, 8'h00, 8'h00,
                8'h00});
      command('{8'h33}, '{`RSP_NAK, `ERR_OPCODE});
      command('{`OP_WRITE, 8'h70, 8'($urandom), data[31:24], data[23:16], data[15:8],
                data[7:0]}, '{`RSP_NAK, `ERR_SUPER});
      command('{`OP_WRITE, 8'h60, 8'h60, 8'h00, 8'h00, 8'h00, 8'h05},
               '{`RSP_NAK, `ERR_MAX});
      command('{`OP_WRITE, 8'h04, 8'h00}, '{`RSP_NAK, `ERR_TIMEOUT});
      check(i_host_uart.frame_errs, 0);
      stop_test();
   end
endmodule : testbench
